/* hdl/mff_regs.svh */
/*
 * Register offsets, field positions, reset values and fixed codes of the frame-field block.
 * Assumes it is included by its bare name inside the design files.
 */
`ifndef MFF_REGS_SVH
`define MFF_REGS_SVH

`define MFF_OFF_CTRL      8'h00
`define MFF_OFF_OWN_LO    8'h04
`define MFF_OFF_OWN_HI    8'h08
`define MFF_OFF_EXT_FCS   8'h0C
`define MFF_OFF_PEER_LO   8'h10
`define MFF_OFF_PEER_HI   8'h14
`define MFF_OFF_STATUS    8'h18
`define MFF_OFF_RX_FCS    8'h1C
`define MFF_OFF_RX_INFO   8'h20
`define MFF_OFF_BAD_CNT   8'h24

`define MFF_CTRL_ADDR48   0
`define MFF_CTRL_BYPASS   1
`define MFF_CTRL_PASSERR  2
`define MFF_CTRL_PAIR_LSB 4

`define MFF_RST_WORD      32'h0000_0000
`define MFF_RST_ADDR      48'h0000_0000_0000
`define MFF_MASK_48       48'hFFFF_FFFF_FFFF
`define MFF_MASK_16       48'h0000_0000_FFFF
`define MFF_AL_LAST_48    3'h5
`define MFF_AL_LAST_16    3'h1
`define MFF_PAIR_TOP_48   6'h2E
`define MFF_PAIR_TOP_16   6'h0E

`define MFF_CRC_POLY      32'h04C1_1DB7
`define MFF_CRC_INIT      32'hFFFF_FFFF
`define MFF_CRC_RESIDUE   32'hC704_DD7B
`define MFF_MAX_FRAME     14'h1FFF
`define MFF_FCS_LAST      2'h3
`define MFF_DLY_FULL      3'h4

`endif

/* hdl/mff_pkg.sv */
/*
 * Types of the frame-field block: carriers for bus, octet streams and frame reports.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mff_pkg;

    // Frame type in transmit order, first symbol in the msb
    typedef enum logic [1:0] {
        MFF_FT_MAC  = 2'h0,
        MFF_FT_LLC  = 2'h1,
        MFF_FT_MGMT = 2'h2,
        MFF_FT_RSVD = 2'h3
    } mff_ftype_type;

    typedef enum logic [2:0] {
        MFF_ACT_NO_RESP = 3'h0,
        MFF_ACT_REQ_RSP = 3'h1,
        MFF_ACT_RESP    = 3'h2
    } mff_action_type;

    typedef enum {TX_IDLE, TX_FC, TX_DA, TX_SA, TX_DATA, TX_FCS} mff_tx_state_type;
    typedef enum {RX_IDLE, RX_FC, RX_DA, RX_SA, RX_BODY} mff_rx_state_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } mff_apb_req_type;

    typedef struct packed {
        logic        start;
        logic [2:0]  action;
        logic [2:0]  prio;
        logic        da_own;
        logic [47:0] da;
    } mff_tx_req_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } mff_octet_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
        logic       ebit;
    } mff_phy_tx_type;

    typedef struct packed {
        logic       sd;
        logic       valid;
        logic [7:0] data;
        logic       ed;
        logic       ebit;
    } mff_phy_rx_type;

    typedef struct packed {
        logic        valid;
        logic        good;
        logic        deliver;
        logic        bcast;
        logic        group;
        logic        fc_undef;
        logic [2:0]  action;
        logic [2:0]  prio;
        logic [31:0] fcs;
    } mff_rx_end_type;

endpackage

/* hdl/mff_frame_fields.sv */
/*
 * MAC frame fields of a token-bus station: frame control, addresses, data unit and
 * the 32-bit frame check, octet-wide in both directions, with an APB register slave.
 * Assumes PHY and LLC logic on the same clock; octet bit 0 is the first bit on the medium.
 */
// Chosen here: the address map and the APB interface to the registers.
// Behaviour
// - Type bits 01 LLC, 10 and 11 reserved
// - Three priority bits, 111 highest
// - Undefined control patterns handled freely
// - Destination address first, source address next
// - Address length 16 or 48, configured
// - First destination bit: individual or group
// - Second bit local/universal, 48-bit only
// - All-ones destination is broadcast, accepted
// - Irrelevant destination may carry own address
// - Source matches destination format, I/G zero
// - Address integer, last bit most significant
// - Contention pairs taken from most significant
// - Data unit bit order passed unchanged
// - Thirty-two bit check with given generator
// - Preset ones, send complemented remainder
// - Check sent highest-degree coefficient first
// - Receiver preset ones, fixed residue expected
// - Optional bypass sends external check value
// - Optional delivery of errored frames flagged
// - At most 8191 octets between delimiters
// - Originator sends end error bit zero
`timescale 1ns/1ns
`default_nettype none
`include "mff_regs.svh"

module mff_frame_fields (
    // Clock and reset
    input  wire logic                    mclk_in,
    input  wire logic                    rst_b_in,
    // APB register slave
    input  wire mff_pkg::mff_apb_req_type apb_in,
    output logic [31:0]                  apb_prdata_out,
    output logic                         apb_pready_out,
    output logic                         apb_pslverr_out,
    // LLC transmit side
    input  wire mff_pkg::mff_tx_req_type  tx_req_in,
    output logic                         tx_busy_out,
    input  wire mff_pkg::mff_octet_type   llc_tx_in,
    output logic                         llc_tx_ready_out,
    // PHY transmit side
    output var mff_pkg::mff_phy_tx_type   phy_tx_out,
    input  wire logic                    phy_tx_ready_in,
    // PHY receive side
    input  wire mff_pkg::mff_phy_rx_type  phy_rx_in,
    // LLC receive side
    output var mff_pkg::mff_octet_type    llc_rx_out,
    output var mff_pkg::mff_rx_end_type   rx_end_out,
    output logic                         rx_bad_out
);
    import mff_pkg::*;

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    // Octet enters lsb first, i.e. in medium order
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[31] ^ d[i]) begin
                r = {r[30:0], 1'b0} ^ `MFF_CRC_POLY;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Configuration and status registers
    logic        addr48_q, bypass_q, passerr_q;
    logic [4:0]  pair_idx_q;
    logic [47:0] own_q, peer_q;
    logic [31:0] extfcs_q, rx_fcs_q, prdata_q;
    logic [15:0] bad_cnt_q;
    logic [15:0] rx_info_q;
    logic        pready_q, pslverr_q;

    // Address length and numeric view
    wire logic [47:0] amask    = addr48_q ? `MFF_MASK_48 : `MFF_MASK_16;
    wire logic [2:0]  al_last  = addr48_q ? `MFF_AL_LAST_48 : `MFF_AL_LAST_16;
    wire logic [47:0] own_m    = own_q & amask;
    wire logic [47:0] peer_m   = peer_q & amask;
    wire logic        own_gt   = own_m > peer_m;
    wire logic        own_eq   = own_m == peer_m;
    wire logic [5:0]  pair_top = addr48_q ? `MFF_PAIR_TOP_48 : `MFF_PAIR_TOP_16;
    wire logic [5:0]  pair_pos = pair_top - {pair_idx_q, 1'b0};
    wire logic [1:0]  pair_val = own_m[pair_pos +: 2];

    // Transmit state
    mff_tx_state_type tx_st_q;
    mff_phy_tx_type   ptx_q;
    mff_octet_type    hold_q;
    logic [2:0]       tx_cnt_q;
    logic [31:0]      tx_crc_q;
    logic [7:0]       tx_fc_q;
    logic [47:0]      tx_da_q;
    logic             llc_rdy_q, got_last_q, tx_busy_q;

    // Receive state
    mff_rx_state_type rx_st_q;
    logic [2:0]       rx_cnt_q, rx_dcnt_q;
    logic [31:0]      rx_crc_q;
    logic [7:0]       rx_fc_q;
    logic [47:0]      rx_da_q;
    logic [3:0][7:0]  rx_dly_q;
    logic [13:0]      rx_len_q;
    mff_octet_type    llc_rx_q;
    mff_rx_end_type   rx_end_q;
    logic             rx_bad_q;

    // APB decode
    wire logic [7:0] addr   = apb_in.paddr;
    wire logic       acc    = apb_in.psel & apb_in.penable & ~pready_q;
    wire logic       wr_en  = apb_in.psel & apb_in.penable & apb_in.pwrite & pready_q;
    wire logic       hit    = (addr <= `MFF_OFF_BAD_CNT) && (addr[1:0] == 2'h0);
    wire logic       wr_bad = wr_en && addr == `MFF_OFF_BAD_CNT;
    wire logic [31:0] w     = apb_in.pwdata;

    wire logic [31:0] rd_mux =
        addr == `MFF_OFF_CTRL    ? {23'h0, pair_idx_q, 1'b0, passerr_q, bypass_q, addr48_q} :
        addr == `MFF_OFF_OWN_LO  ? own_q[31:0] :
        addr == `MFF_OFF_OWN_HI  ? {16'h0, own_q[47:32]} :
        addr == `MFF_OFF_EXT_FCS ? extfcs_q :
        addr == `MFF_OFF_PEER_LO ? peer_q[31:0] :
        addr == `MFF_OFF_PEER_HI ? {16'h0, peer_q[47:32]} :
        addr == `MFF_OFF_STATUS  ? {27'h0, tx_busy_q, pair_val, own_eq, own_gt} :
        addr == `MFF_OFF_RX_FCS  ? rx_fcs_q :
        addr == `MFF_OFF_RX_INFO ? {16'h0, rx_info_q} :
        addr == `MFF_OFF_BAD_CNT ? {16'h0, bad_cnt_q} : 32'h0000_0000;

    // Answer in the second access cycle; writes land on the edge that ends it
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `MFF_RST_WORD;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc & ~hit;
            prdata_q  <= (acc && hit && !apb_in.pwrite) ? rd_mux : `MFF_RST_WORD;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            addr48_q   <= 1'b0;
            bypass_q   <= 1'b0;
            passerr_q  <= 1'b0;
            pair_idx_q <= 5'h00;
            own_q      <= `MFF_RST_ADDR;
            peer_q     <= `MFF_RST_ADDR;
            extfcs_q   <= `MFF_RST_WORD;
        end else if (wr_en) begin
            case (addr)
                `MFF_OFF_CTRL: begin
                    addr48_q   <= w[`MFF_CTRL_ADDR48];
                    bypass_q   <= w[`MFF_CTRL_BYPASS];
                    passerr_q  <= w[`MFF_CTRL_PASSERR];
                    pair_idx_q <= w[`MFF_CTRL_PAIR_LSB +: 5];
                end
                `MFF_OFF_OWN_LO:  own_q[31:0]   <= w;
                `MFF_OFF_OWN_HI:  own_q[47:32]  <= w[15:0];
                `MFF_OFF_EXT_FCS: extfcs_q      <= w;
                `MFF_OFF_PEER_LO: peer_q[31:0]  <= w;
                `MFF_OFF_PEER_HI: peer_q[47:32] <= w[15:0];
                default: ;
            endcase
        end
    end

    // Transmit path
    wire logic        tx_load   = ~ptx_q.valid | phy_tx_ready_in;
    wire logic [47:0] sa_val    = own_m & ~48'h0000_0000_0001;
    wire logic [7:0]  da_oct    = tx_da_q[{tx_cnt_q, 3'h0} +: 8];
    wire logic [7:0]  sa_oct    = sa_val[{tx_cnt_q, 3'h0} +: 8];
    wire logic [31:0] fcs_src   = bypass_q ? extfcs_q : ~tx_crc_q;
    wire logic [31:0] fcs_sh    = fcs_src << {tx_cnt_q[1:0], 3'h0};
    wire logic [7:0]  fcs_oct   = rev8(fcs_sh[31:24]);
    wire logic [7:0]  fcs_first = rev8(~tx_crc_q[31:24]);
    wire logic        hold_take = llc_tx_in.valid & llc_rdy_q;
    wire logic        hold_used = (tx_st_q == TX_DATA) & tx_load & hold_q.valid;
    wire logic        hold_nv   = hold_take | (hold_q.valid & ~hold_used);
    wire logic        last_nv   = got_last_q | (hold_take & llc_tx_in.last);

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            tx_st_q    <= TX_IDLE;
            ptx_q      <= '0;
            hold_q     <= '0;
            tx_cnt_q   <= 3'h0;
            tx_crc_q   <= `MFF_CRC_INIT;
            tx_fc_q    <= 8'h00;
            tx_da_q    <= `MFF_RST_ADDR;
            llc_rdy_q  <= 1'b0;
            got_last_q <= 1'b0;
            tx_busy_q  <= 1'b0;
        end else begin
            llc_rdy_q  <= ~hold_nv & ~last_nv & (tx_st_q != TX_IDLE);
            got_last_q <= last_nv;
            if (phy_tx_ready_in) begin
                ptx_q.valid <= 1'b0;
            end
            if (hold_take) begin
                hold_q <= '{valid: 1'b1, data: llc_tx_in.data, last: llc_tx_in.last};
            end
            case (tx_st_q)
                TX_IDLE: if (tx_req_in.start) begin
                    // Only LLC data frames originate here
                    tx_fc_q    <= rev8({MFF_FT_LLC, tx_req_in.action, tx_req_in.prio});
                    tx_da_q    <= tx_req_in.da_own ? sa_val : tx_req_in.da & amask;
                    tx_crc_q   <= `MFF_CRC_INIT;
                    got_last_q <= 1'b0;
                    tx_busy_q  <= 1'b1;
                    tx_st_q    <= TX_FC;
                end
                TX_FC: if (tx_load) begin
                    ptx_q    <= '{valid: 1'b1, data: tx_fc_q, last: 1'b0, ebit: 1'b0};
                    tx_crc_q <= crc_step(tx_crc_q, tx_fc_q);
                    tx_cnt_q <= 3'h0;
                    tx_st_q  <= TX_DA;
                end
                TX_DA: if (tx_load) begin
                    ptx_q    <= '{valid: 1'b1, data: da_oct, last: 1'b0, ebit: 1'b0};
                    tx_crc_q <= crc_step(tx_crc_q, da_oct);
                    tx_cnt_q <= (tx_cnt_q == al_last) ? 3'h0 : tx_cnt_q + 3'h1;
                    if (tx_cnt_q == al_last) begin
                        tx_st_q <= TX_SA;
                    end
                end
                TX_SA: if (tx_load) begin
                    ptx_q    <= '{valid: 1'b1, data: sa_oct, last: 1'b0, ebit: 1'b0};
                    tx_crc_q <= crc_step(tx_crc_q, sa_oct);
                    tx_cnt_q <= (tx_cnt_q == al_last) ? 3'h0 : tx_cnt_q + 3'h1;
                    if (tx_cnt_q == al_last) begin
                        tx_st_q <= TX_DATA;
                    end
                end
                TX_DATA: if (tx_load && hold_q.valid) begin
                    // Octets go out exactly as the LLC gave them
                    ptx_q        <= '{valid: 1'b1, data: hold_q.data, last: 1'b0, ebit: 1'b0};
                    tx_crc_q     <= crc_step(tx_crc_q, hold_q.data);
                    hold_q.valid <= 1'b0;
                    if (hold_q.last) begin
                        tx_cnt_q <= 3'h0;
                        tx_st_q  <= TX_FCS;
                    end
                end
                TX_FCS: if (tx_load) begin
                    // End delimiter error bit is never set by the originator
                    ptx_q    <= '{valid: 1'b1, data: fcs_oct,
                                  last: tx_cnt_q[1:0] == `MFF_FCS_LAST, ebit: 1'b0};
                    tx_cnt_q <= tx_cnt_q + 3'h1;
                    if (tx_cnt_q[1:0] == `MFF_FCS_LAST) begin
                        tx_busy_q <= 1'b0;
                        tx_st_q   <= TX_IDLE;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // Receive path; four octets lag so the check field never reaches the LLC
    wire logic [47:0] rx_da_m  = rx_da_q & amask;
    wire logic [7:0]  fc_rd    = rev8(rx_fc_q);
    wire logic        fc_llc   = fc_rd[7:6] == MFF_FT_LLC;
    wire logic        fc_undef = ~fc_llc | (fc_rd[5:3] > MFF_ACT_RESP);
    wire logic        rx_group = rx_da_q[0];
    wire logic        rx_lu    = addr48_q ? rx_da_q[1] : 1'b1;
    wire logic        rx_bcast = rx_da_m == amask;
    wire logic        rx_match = rx_group | (rx_da_m == own_m);
    wire logic        rx_take  = ~fc_undef & rx_match;
    wire logic        rx_resok = rx_crc_q == `MFF_CRC_RESIDUE;
    wire logic        rx_good  = (rx_st_q == RX_BODY) & (rx_dcnt_q == `MFF_DLY_FULL) & rx_resok
                               & (rx_len_q <= `MFF_MAX_FRAME) & ~phy_rx_in.ebit;
    wire logic [31:0] rx_fcs   = {rev8(rx_dly_q[3]), rev8(rx_dly_q[2]),
                                  rev8(rx_dly_q[1]), rev8(rx_dly_q[0])};
    wire logic        rx_in_fr = rx_st_q != RX_IDLE;

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            rx_st_q   <= RX_IDLE;
            rx_cnt_q  <= 3'h0;
            rx_dcnt_q <= 3'h0;
            rx_crc_q  <= `MFF_CRC_INIT;
            rx_fc_q   <= 8'h00;
            rx_da_q   <= `MFF_RST_ADDR;
            rx_dly_q  <= '0;
            rx_len_q  <= 14'h0000;
            llc_rx_q  <= '0;
            rx_end_q  <= '0;
            rx_bad_q  <= 1'b0;
            rx_fcs_q  <= `MFF_RST_WORD;
            rx_info_q <= 16'h0000;
        end else begin
            llc_rx_q.valid <= 1'b0;
            rx_end_q.valid <= 1'b0;
            rx_bad_q       <= 1'b0;
            if (phy_rx_in.sd) begin
                rx_crc_q  <= `MFF_CRC_INIT;
                rx_cnt_q  <= 3'h0;
                rx_dcnt_q <= 3'h0;
                rx_len_q  <= 14'h0000;
                rx_st_q   <= RX_FC;
            end else if (phy_rx_in.ed && rx_in_fr) begin
                // Errored frames may still be handed up when software asks
                rx_end_q  <= '{valid: 1'b1, good: rx_good,
                               deliver: rx_take & (rx_good | passerr_q),
                               bcast: rx_bcast, group: rx_group, fc_undef: fc_undef,
                               action: fc_rd[5:3], prio: fc_rd[2:0], fcs: rx_fcs};
                rx_bad_q  <= ~rx_good;
                rx_fcs_q  <= rx_fcs;
                rx_info_q <= {3'h0, rx_good, rx_bcast, rx_group, rx_lu, fc_undef, rx_fc_q};
                rx_st_q   <= RX_IDLE;
            end else if (phy_rx_in.valid && rx_in_fr) begin
                rx_crc_q <= crc_step(rx_crc_q, phy_rx_in.data);
                rx_len_q <= (rx_len_q == 14'h3FFF) ? rx_len_q : rx_len_q + 14'h0001;
                case (rx_st_q)
                    RX_FC: begin
                        rx_fc_q <= phy_rx_in.data;
                        rx_st_q <= RX_DA;
                    end
                    RX_DA: begin
                        rx_da_q[{rx_cnt_q, 3'h0} +: 8] <= phy_rx_in.data;
                        rx_cnt_q <= (rx_cnt_q == al_last) ? 3'h0 : rx_cnt_q + 3'h1;
                        if (rx_cnt_q == al_last) begin
                            rx_st_q <= RX_SA;
                        end
                    end
                    RX_SA: begin
                        rx_cnt_q <= (rx_cnt_q == al_last) ? 3'h0 : rx_cnt_q + 3'h1;
                        if (rx_cnt_q == al_last) begin
                            rx_st_q <= RX_BODY;
                        end
                    end
                    RX_BODY: begin
                        rx_dly_q <= {rx_dly_q[2:0], phy_rx_in.data};
                        if (rx_dcnt_q == `MFF_DLY_FULL) begin
                            llc_rx_q <= '{valid: rx_take, data: rx_dly_q[3], last: 1'b0};
                        end else begin
                            rx_dcnt_q <= rx_dcnt_q + 3'h1;
                        end
                    end
                    default: rx_st_q <= RX_IDLE;
                endcase
            end
        end
    end

    // A software clear in the same cycle as a hardware increment loads one
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            bad_cnt_q <= 16'h0000;
        end else if (rx_bad_q) begin
            bad_cnt_q <= wr_bad ? 16'h0001 : bad_cnt_q + 16'h0001;
        end else if (wr_bad) begin
            bad_cnt_q <= 16'h0000;
        end
    end

    assign apb_prdata_out   = prdata_q;
    assign apb_pready_out   = pready_q;
    assign apb_pslverr_out  = pslverr_q;
    assign tx_busy_out      = tx_busy_q;
    assign llc_tx_ready_out = llc_rdy_q;
    assign phy_tx_out       = ptx_q;
    assign llc_rx_out       = llc_rx_q;
    assign rx_end_out       = rx_end_q;
    assign rx_bad_out       = rx_bad_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    a_fc_type_llc: assert property ((tx_st_q == TX_FC && tx_load) |=> ptx_q.data[1:0] == 2'h2)
        else $error("transmitted frame type not LLC data");
    a_sa_ig_zero: assert property ((tx_st_q == TX_SA && tx_load && tx_cnt_q == 3'h0) |=> !ptx_q.data[0])
        else $error("source address group bit sent as one");
    a_fcs_first_oct: assert property ((tx_st_q == TX_FCS && tx_load && tx_cnt_q == 3'h0 && !bypass_q)
        |=> ptx_q.data == $past(fcs_first))
        else $error("first check octet not top of complemented remainder");
    a_tx_ebit_zero: assert property (ptx_q.valid && ptx_q.last |-> !ptx_q.ebit)
        else $error("originated frame carries error bit");
    a_tx_hold_oct: assert property (ptx_q.valid && !phy_tx_ready_in |=> ptx_q.valid && $stable(ptx_q.data))
        else $error("transmit octet changed before taken");
    a_rx_bad_res: assert property ((phy_rx_in.ed && rx_st_q == RX_BODY && !rx_resok) |=> rx_bad_q)
        else $error("residue mismatch not flagged");
    a_rx_bcast_ok: assert property (rx_end_q.valid && rx_end_q.bcast && rx_end_q.good && !rx_end_q.fc_undef
        |-> rx_end_q.deliver)
        else $error("good broadcast frame not delivered");
    a_rx_err_pass: assert property (rx_end_q.valid && rx_end_q.deliver && !rx_end_q.good |-> passerr_q)
        else $error("errored frame delivered without pass option");
    a_apb_one_beat: assert property (pready_q |=> !pready_q)
        else $error("ready held beyond one cycle");

    c_tx_frame: cover property (ptx_q.valid && ptx_q.last && phy_tx_ready_in);
    c_rx_good: cover property (rx_end_q.valid && rx_end_q.good && rx_end_q.deliver);
    c_rx_bad: cover property (rx_bad_q ##1 wr_bad);
    c_tx_bypass: cover property (tx_st_q == TX_FCS && bypass_q && tx_load);

endmodule

`default_nettype wire

/* tb/mff_phy_model.sv */
/* Loopback physical-layer model: takes transmitted octets, replays them as a received frame.
   Assumes the frame block's clock; stalls ready and corrupts the last check octet on request. */
`timescale 1ns/1ns
`default_nettype none
module mff_phy_model (
    // Clock and test controls
    input  wire logic                    mclk_in,
    input  wire logic                    slow_in,
    input  wire logic                    corrupt_in,
    // Frame block side
    input  wire mff_pkg::mff_phy_tx_type tx_in,
    output logic                         tx_ready_out,
    output var mff_pkg::mff_phy_rx_type  rx_out
);
    import mff_pkg::*;
    wire        take = tx_in.valid & tx_ready_out;
    logic       inf_q = 1'b0;
    logic       tk1_q = 1'b0;
    logic       l1_q = 1'b0;
    logic       l2_q = 1'b0;
    logic [7:0] d1_q = 8'h00;
    initial begin
        tx_ready_out = 1'b0;
        rx_out = '0;
    end
    always @(posedge mclk_in) begin
        tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
        tk1_q <= take;
        d1_q <= tx_in.data ^ {7'h00, corrupt_in & tx_in.last};
        l1_q <= take & tx_in.last;
        l2_q <= l1_q;
        if (take) inf_q <= ~tx_in.last;
        rx_out.sd <= take & ~inf_q;
        rx_out.valid <= tk1_q;
        // Idle data toggles so a stale octet is never mistaken for fresh
        rx_out.data <= tk1_q ? d1_q : ~rx_out.data;
        rx_out.ed <= l2_q;
        rx_out.ebit <= 1'b0;
    end
endmodule
`default_nettype wire

/* tb/mff_frame_fields_tb_top.sv */
/* Self-checking bench of the frame-field block: APB setup, looped-back frames, results.
   Assumes the loopback physical-layer model and a 250 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
`include "mff_regs.svh"
module mff_frame_fields_tb_top;
    import mff_pkg::*;
    logic clk = 0, rst_b = 0, slow = 0, bad = 0, got_bad = 0, err = 0, pass = 0;
    logic pready, perr, busy, lrdy, prdy, rxbad;
    logic [31:0] prdata, rd;
    mff_apb_req_type apb = '0;
    mff_tx_req_type req = '0;
    mff_octet_type ltx = '0, lrx;
    mff_phy_tx_type ptx;
    mff_phy_rx_type prx;
    mff_rx_end_type rend, ends = '0;
    int n_mismatch = 0, samples_checked = 0;
    logic [7:0] txq[$], rxq[$];
    mff_frame_fields i_dut (.mclk_in(clk), .rst_b_in(rst_b), .apb_in(apb),
        .apb_prdata_out(prdata), .apb_pready_out(pready), .apb_pslverr_out(perr),
        .tx_req_in(req), .tx_busy_out(busy), .llc_tx_in(ltx), .llc_tx_ready_out(lrdy),
        .phy_tx_out(ptx), .phy_tx_ready_in(prdy), .phy_rx_in(prx), .llc_rx_out(lrx),
        .rx_end_out(rend), .rx_bad_out(rxbad));
    mff_phy_model i_phy (.mclk_in(clk), .slow_in(slow), .corrupt_in(bad), .tx_in(ptx),
        .tx_ready_out(prdy), .rx_out(prx));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        if (ptx.valid & prdy) txq.push_back(ptx.data);
        if (ptx.valid) chk("end error bit", ptx.ebit, 0);
        if (lrx.valid) rxq.push_back(lrx.data);
    end
    task automatic chk(string what, logic [47:0] got, logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic guard(int n);
        if (n >= 999) begin
            n_mismatch++;
            test_done();
        end
    endtask
    task automatic apb_x(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk) apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk) apb.penable <= 1'b1;
        for (n = 0; n < 999; n++) begin
            @(posedge clk);
            if (pready) break;
        end
        guard(n);
        rd = prdata;
        err = perr;
        apb <= '0;
    endtask
    task automatic send_frame(logic corrupt, logic slw, logic byp, logic [2:0] p, int al);
        int i, n, k;
        logic [31:0] fcs, got;
        logic [47:0] da = '0, sa = '0;
        txq.delete();
        rxq.delete();
        bad <= corrupt;
        slow <= slw;
        @(posedge clk) req <= '{1'b1, 3'h1, p, 1'b0, 48'hFFFF_FFFF_FFFF};
        @(posedge clk) req.start <= 1'b0;
        for (i = 0; i < 3; i++) begin
            ltx <= '{1'b1, 8'h3C + 8'(i), i == 2};
            for (n = 0; n < 999; n++) begin
                @(posedge clk);
                if (lrdy) break;
            end
            guard(n);
        end
        ltx <= '0;
        for (n = 0; n < 999; n++) begin
            @(posedge clk);
            if (rend.valid) break;
        end
        guard(n);
        ends = rend;
        got_bad = rxbad;
        k = 2 * al + 4;
        for (i = 0; i < al; i++) begin
            da[8 * i +: 8] = txq[1 + i];
            sa[8 * i +: 8] = txq[1 + al + i];
        end
        chk("frame octets", txq.size(), k + 4);
        chk("fc", txq[0], {p[0], p[1], p[2], 3'b100, 2'b10});
        chk("da", da, al == 6 ? 48'hFFFF_FFFF_FFFF : 48'hFFFF);
        chk("sa", sa, al == 6 ? 48'hABCD_1234_5678 : 48'h5678);
        chk("tx data", {txq[k - 1], txq[k - 2], txq[k - 3]}, 24'h3E3D3C);
        chk("rx data", {rxq[2], rxq[1], rxq[0]}, 24'h3E3D3C);
        fcs = `MFF_CRC_INIT;
        for (i = 0; i < 8 * k; i++)
            fcs = {fcs[30:0], 1'b0} ^ ((fcs[31] ^ txq[i / 8][i % 8]) ? `MFF_CRC_POLY : 32'h0);
        fcs = byp ? 32'hA5C3_0F81 : ~fcs;
        for (i = 0; i < 32; i++) got[31 - i] = txq[k + i / 8][i % 8];
        chk("tx fcs", got, fcs);
        chk("rx fcs", ends.fcs, fcs ^ {24'h0, corrupt, 7'h0});
        chk("rx good", ends.good, !corrupt && !byp);
        chk("rx bad", got_bad, corrupt || byp);
        chk("deliver", ends.deliver, !byp && (!corrupt || pass));
        chk("group bcast", {ends.group, ends.bcast}, 2'b11);
        chk("prio action", {ends.prio, ends.action}, {p, 3'h1});
        chk("busy", busy, 0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb_x(1'b1, `MFF_OFF_CTRL, 32'h1);
        apb_x(1'b1, `MFF_OFF_OWN_LO, 32'h1234_5679);
        apb_x(1'b1, `MFF_OFF_OWN_HI, 32'hABCD);
        apb_x(1'b0, `MFF_OFF_CTRL, 32'h0);
        chk("ctrl", rd, 32'h1);
        apb_x(1'b0, `MFF_OFF_STATUS, 32'h0);
        chk("status", rd, 32'h9);
        apb_x(1'b0, 8'h28, 32'h0);
        chk("unmapped", {err, rd}, {1'b1, 32'h0});
        send_frame(1'b0, 1'b0, 1'b0, 3'h7, 6);
        apb_x(1'b0, `MFF_OFF_RX_INFO, 32'h0);
        chk("rx info", rd, 32'h1EF2);
        apb_x(1'b1, `MFF_OFF_CTRL, 32'h5);
        pass = 1'b1;
        send_frame(1'b1, 1'b1, 1'b0, 3'h0, 6);
        pass = 1'b0;
        apb_x(1'b1, `MFF_OFF_EXT_FCS, 32'hA5C3_0F81);
        apb_x(1'b1, `MFF_OFF_CTRL, 32'h3);
        send_frame(1'b0, 1'b0, 1'b1, 3'h5, 6);
        apb_x(1'b1, `MFF_OFF_CTRL, 32'h0);
        send_frame(1'b0, 1'b0, 1'b0, 3'h2, 2);
        apb_x(1'b0, `MFF_OFF_BAD_CNT, 32'h0);
        chk("bad count", rd, 32'h2);
        test_done();
    end
endmodule
`default_nettype wire
